/* File: core/mht_params.svh */
/*
 * Constants for the serial configuration and hold timing block.
 * Assumes inclusion by its bare name from the package and the modules.
 */
`ifndef MHT_PARAMS_SVH
`define MHT_PARAMS_SVH

// Widths
`define MHT_SLOT_W      16
`define MHT_CFG_W       32
`define MHT_ID_W        32
`define MHT_CHAN_W      3
`define MHT_ADDR_W      5
`define MHT_SYNC_W      18

// Fields of the slot-select number
`define MHT_SLOT_LSB    0
`define MHT_SLOT_MSB    4
`define MHT_CHAS_LSB    5
`define MHT_CHAS_MSB    9

// Configuration bits
`define MHT_CFG_TH_EN   0
`define MHT_CFG_EDGE    1
`define MHT_CFG_SRC_CHS 2

// Bit positions in the synchroniser vector
`define MHT_IX_SCLK     0
`define MHT_IX_SDI      1
`define MHT_IX_DA       2
`define MHT_IX_SZSEL    3
`define MHT_IX_SCAN     4
`define MHT_IX_SCON     5
`define MHT_IX_HPIN     6
`define MHT_IX_CHOLD    7
`define MHT_IX_SLOT     8
`define MHT_IX_CHAS     13

// Reset, default and step values
`define MHT_ID_DEFAULT  32'h1234_5678
`define MHT_ZERO_SLOT   16'h0000
`define MHT_ZERO_CFG    32'h0000_0000
`define MHT_ZERO_ID     32'h0000_0000
`define MHT_ZERO_CHAN   3'h0
`define MHT_ONE_CHAN    3'h1
// Serial clock, slot-zero select and chassis line idle high
`define MHT_IDLE_SYNC   18'h0_0089

`endif

/* File: core/mht_pkg.sv */
/*
 * Types for the serial configuration and hold timing block.
 * Assumes mht_params.svh is on the include path.
 */
`include "mht_params.svh"

package mht_pkg;

    typedef struct packed {
        logic [`MHT_SYNC_W-1:0] s1;
        logic [`MHT_SYNC_W-1:0] s2;
        logic [`MHT_SYNC_W-1:0] s3;
    } mht_sync_t;

    typedef struct packed {
        logic [`MHT_SLOT_W-1:0] slot_sr;
        logic                   ss_n;
        logic [`MHT_CFG_W-1:0]  cfg;
        logic [`MHT_ID_W-1:0]   id_sr;
        logic                   ser_out;
        logic [`MHT_CHAN_W-1:0] chan;
        logic                   mux_en;
        logic                   hold;
        logic                   th_val;
        logic                   th_oe;
        logic                   pin_o;
        logic                   pin_oe;
        logic                   chs_o;
        logic                   chs_oe;
    } mht_state_t;

endpackage

/* File: core/mht_sync.sv */
/*
 * Two-flop synchroniser bank with a third stage for edge detection.
 * Assumes asynchronous inputs and an active-low reset already synchronised.
 */
`include "mht_params.svh"

module mht_sync
    import mht_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    // Raw and synchronised levels
    input  wire logic [`MHT_SYNC_W-1:0] async_i,
    output logic      [`MHT_SYNC_W-1:0] level_o,
    output logic      [`MHT_SYNC_W-1:0] prev_o
);

    mht_sync_t st_r;
    mht_sync_t st_nxt;

    // First stage feeds only the second stage
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = async_i;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // Idle levels keep a false edge from following reset
            st_r <= '{`MHT_IDLE_SYNC, `MHT_IDLE_SYNC, `MHT_IDLE_SYNC};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level_o = st_r.s2;
    assign prev_o  = st_r.s3;

endmodule

/* File: core/mht_core.sv */
/*
 * Serial configuration, identification readout, scan multiplexer counter
 * and hold trigger routing of an eight-channel track-and-hold module.
 * Assumes all pin inputs are asynchronous to REF_CLK_I and that the serial
 * clock runs well below a quarter of REF_CLK_I; the wire levels of two-way
 * pins are resolved outside from the enables.
 */
// Function
// - Data/address flag low data, high address
// - Slot-zero select low routes bits to slot register
// - Capture serial input on serial clock rise
// - Slot-zero select low deselects this module
// - Select only on matching slot and chassis
// - Shift 32 identification bits then zeros
// - Deselect reloads identification shift contents
// - Scan pulse rise advances multiplexer channel
// - Track/hold driver off until configuration enables
// - Level mode pin source: follow, invert chassis
// - Level mode chassis source: both inverse
// - Edge mode: pin rise enters hold
// - Edge mode: chassis line fall enters hold
// - Edge mode: scan control change returns hold to track
// - Track/hold output low track, high hold
// - Serial clock idles high, second edge latch
// - Reset restores power-up state
// - Scan control enables output and reloads counter
`include "mht_params.svh"

module mht_core
    import mht_pkg::*;
#(
    parameter logic [`MHT_ID_W-1:0] MODULE_ID = `MHT_ID_DEFAULT // arbitrary
)(
    // Clock and reset
    input  wire logic                   REF_CLK_I,
    input  wire logic                   RST_N_I,
    // Serial link
    input  wire logic                   SERIAL_CLOCK_LINE_I,
    input  wire logic                   SERIAL_IN_LINE_I,
    input  wire logic                   HOST_DATA_ADDR_FLAG_I,
    input  wire logic                   SLOT_ZERO_SELECT_N_I,
    output logic                        SERIAL_OUT_LINE_O,
    output logic                        SLOT_SELECT_N_O,
    // Slot straps
    input  wire logic [`MHT_ADDR_W-1:0] SLOT_NUMBER_I,
    input  wire logic [`MHT_ADDR_W-1:0] CHASSIS_ADDR_I,
    // Configuration
    output logic      [`MHT_CFG_W-1:0]  CONFIG_O,
    // Scanning
    input  wire logic                   SCAN_ADVANCE_PULSE_I,
    input  wire logic                   SCAN_CONTROL_IN_I,
    output logic      [`MHT_CHAN_W-1:0] MUX_CHANNEL_O,
    output logic                        MUX_ENABLE_O,
    // Hold trigger pin, two-way
    input  wire logic                   HOLD_TRIGGER_PIN_I,
    output logic                        HOLD_TRIGGER_PIN_O,
    output logic                        HOLD_TRIGGER_PIN_OE_O,
    // Chassis hold line, open collector
    input  wire logic                   CHASSIS_HOLD_LINE_I,
    output logic                        CHASSIS_HOLD_LINE_O,
    output logic                        CHASSIS_HOLD_LINE_OE_O,
    // Track/hold output
    output logic                        TRACK_HOLD_O,
    output logic                        TRACK_HOLD_OE_O
);

    logic                   rst_meta_r;
    logic                   rst_n_r;
    logic [`MHT_SYNC_W-1:0] lvl;
    logic [`MHT_SYNC_W-1:0] prv;
    logic                   sclk_rise;
    logic                   sz_rise;
    logic                   sz_low;
    logic                   scan_rise;
    logic                   scon_chg;
    logic                   pin_rise;
    logic                   chs_fall;
    logic                   pin_lvl;
    logic                   chs_lvl;
    logic                   scon_lvl;
    mht_state_t             st_r;
    mht_state_t             st_nxt;

    // Reset release through two flops
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    mht_sync u_sync (
        .clk_i   (REF_CLK_I),
        .rst_n_i (rst_n_r),
        .async_i ({CHASSIS_ADDR_I, SLOT_NUMBER_I, CHASSIS_HOLD_LINE_I,
                   HOLD_TRIGGER_PIN_I, SCAN_CONTROL_IN_I,
                   SCAN_ADVANCE_PULSE_I, SLOT_ZERO_SELECT_N_I,
                   HOST_DATA_ADDR_FLAG_I, SERIAL_IN_LINE_I,
                   SERIAL_CLOCK_LINE_I}),
        .level_o (lvl),
        .prev_o  (prv)
    );

    function automatic logic rise(input logic now, input logic was);
        rise = now & ~was;
    endfunction

    // Data is latched on the second edge of an idle-high clock
    assign sclk_rise = rise(lvl[`MHT_IX_SCLK], prv[`MHT_IX_SCLK]);
    assign sz_rise   = rise(lvl[`MHT_IX_SZSEL], prv[`MHT_IX_SZSEL]);
    assign sz_low    = ~lvl[`MHT_IX_SZSEL];
    assign scan_rise = rise(lvl[`MHT_IX_SCAN], prv[`MHT_IX_SCAN]);
    assign scon_chg  = lvl[`MHT_IX_SCON] ^ prv[`MHT_IX_SCON];
    assign pin_rise  = rise(lvl[`MHT_IX_HPIN], prv[`MHT_IX_HPIN]);
    assign chs_fall  = rise(prv[`MHT_IX_CHOLD], lvl[`MHT_IX_CHOLD]);
    assign pin_lvl   = lvl[`MHT_IX_HPIN];
    assign chs_lvl   = lvl[`MHT_IX_CHOLD];
    assign scon_lvl  = lvl[`MHT_IX_SCON];

    always_comb begin
        st_nxt = st_r;

        // Slot-number entry and module selection
        if (sz_low) begin
            st_nxt.ss_n    = 1'b1;
            st_nxt.id_sr   = MODULE_ID;
            st_nxt.ser_out = 1'b0;
            if (sclk_rise) begin
                st_nxt.slot_sr = {st_r.slot_sr[`MHT_SLOT_W-2:0],
                                  lvl[`MHT_IX_SDI]};
            end
        end else if (sz_rise) begin
            if (st_r.slot_sr[`MHT_SLOT_MSB:`MHT_SLOT_LSB]
                    == lvl[`MHT_IX_SLOT +: `MHT_ADDR_W]
                && st_r.slot_sr[`MHT_CHAS_MSB:`MHT_CHAS_LSB]
                    == lvl[`MHT_IX_CHAS +: `MHT_ADDR_W]) begin
                st_nxt.ss_n = 1'b0;
            end
        end else if (st_r.ss_n) begin
            st_nxt.id_sr   = MODULE_ID;
            st_nxt.ser_out = 1'b0;
        end else if (sclk_rise) begin
            if (!lvl[`MHT_IX_DA]) begin
                st_nxt.cfg = {st_r.cfg[`MHT_CFG_W-2:0],
                              lvl[`MHT_IX_SDI]};
            end else begin
                // Zeros follow the identification word
                st_nxt.ser_out = st_r.id_sr[`MHT_ID_W-1];
                st_nxt.id_sr   = {st_r.id_sr[`MHT_ID_W-2:0], 1'b0};
            end
        end

        // Counter reload and output enable from scan control
        if (!scon_lvl) begin
            st_nxt.chan   = `MHT_ZERO_CHAN;
            st_nxt.mux_en = 1'b0;
        end else begin
            st_nxt.mux_en = 1'b1;
            if (scan_rise) begin
                st_nxt.chan = st_r.chan + `MHT_ONE_CHAN;
            end
        end

        // Hold trigger routing
        st_nxt.chs_o = 1'b0;
        if (!st_r.cfg[`MHT_CFG_EDGE]) begin
            if (!st_r.cfg[`MHT_CFG_SRC_CHS]) begin
                st_nxt.hold   = pin_lvl;
                st_nxt.chs_oe = pin_lvl;
                st_nxt.pin_oe = 1'b0;
            end else begin
                st_nxt.hold   = ~chs_lvl;
                st_nxt.pin_o  = ~chs_lvl;
                st_nxt.pin_oe = 1'b1;
                st_nxt.chs_oe = 1'b0;
            end
        end else begin
            // A trigger in the cycle of a release wins, so it is not lost
            if (!st_r.cfg[`MHT_CFG_SRC_CHS] && pin_rise) begin
                st_nxt.hold = 1'b1;
            end else if (st_r.cfg[`MHT_CFG_SRC_CHS] && chs_fall) begin
                st_nxt.hold = 1'b1;
            end else if (scon_chg) begin
                st_nxt.hold = 1'b0;
            end
            // Pass the hold state on to the other trigger path
            st_nxt.chs_oe = ~st_r.cfg[`MHT_CFG_SRC_CHS] & st_r.hold;
            st_nxt.pin_oe = st_r.cfg[`MHT_CFG_SRC_CHS];
            st_nxt.pin_o  = st_r.hold;
        end

        // Track is low, hold is high, driver off until enabled
        st_nxt.th_oe  = st_r.cfg[`MHT_CFG_TH_EN];
        st_nxt.th_val = st_r.cfg[`MHT_CFG_TH_EN] & st_r.hold;
    end

    always_ff @(posedge REF_CLK_I or negedge rst_n_r) begin
        if (!rst_n_r) begin
            st_r         <= '0;
            st_r.ss_n    <= 1'b1;
            st_r.slot_sr <= `MHT_ZERO_SLOT;
            st_r.cfg     <= `MHT_ZERO_CFG;
            st_r.id_sr   <= `MHT_ZERO_ID;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign SERIAL_OUT_LINE_O      = st_r.ser_out;
    assign SLOT_SELECT_N_O        = st_r.ss_n;
    assign CONFIG_O               = st_r.cfg;
    assign MUX_CHANNEL_O          = st_r.chan;
    assign MUX_ENABLE_O           = st_r.mux_en;
    assign HOLD_TRIGGER_PIN_O     = st_r.pin_o;
    assign HOLD_TRIGGER_PIN_OE_O  = st_r.pin_oe;
    assign CHASSIS_HOLD_LINE_O    = st_r.chs_o;
    assign CHASSIS_HOLD_LINE_OE_O = st_r.chs_oe;
    assign TRACK_HOLD_O           = st_r.th_val;
    assign TRACK_HOLD_OE_O        = st_r.th_oe;

endmodule

/* File: tb/mht_core_asserts.sv */
/*
 * Concurrent checks on the ports of mht_core.
 * Assumes binding into every mht_core instance.
 */
module mht_core_asserts (
    input wire logic        REF_CLK_I,
    input wire logic        RST_N_I,
    input wire logic        SLOT_ZERO_SELECT_N_I,
    input wire logic        HOST_DATA_ADDR_FLAG_I,
    input wire logic        SCAN_CONTROL_IN_I,
    input wire logic        HOLD_TRIGGER_PIN_I,
    input wire logic        CHASSIS_HOLD_LINE_I,
    input wire logic        SLOT_SELECT_N_O,
    input wire logic        SERIAL_OUT_LINE_O,
    input wire logic [31:0] CONFIG_O,
    input wire logic [2:0]  MUX_CHANNEL_O,
    input wire logic        MUX_ENABLE_O,
    input wire logic        TRACK_HOLD_O,
    input wire logic        TRACK_HOLD_OE_O
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);

    chk_zero_desel: assert property (
        (!SLOT_ZERO_SELECT_N_I)[*6] |-> SLOT_SELECT_N_O)
        else $error("module selected during slot entry");
    chk_sel_on_rise: assert property (
        $fell(SLOT_SELECT_N_O) |-> SLOT_ZERO_SELECT_N_I)
        else $error("selected while slot-zero select low");
    chk_cfg_frozen: assert property (
        !$stable(CONFIG_O) |-> $past(!SLOT_SELECT_N_O))
        else $error("configuration changed while deselected");
    chk_cfg_flag: assert property (
        !$stable(CONFIG_O) |-> $past(!HOST_DATA_ADDR_FLAG_I, 3))
        else $error("configuration changed during read");
    chk_id_idle: assert property (
        SLOT_SELECT_N_O && $past(SLOT_SELECT_N_O, 2) |-> !SERIAL_OUT_LINE_O)
        else $error("serial output active while deselected");
    chk_th_off: assert property (
        !CONFIG_O[0] && !$past(CONFIG_O[0]) && !$past(CONFIG_O[0], 2)
        |-> !TRACK_HOLD_OE_O)
        else $error("track/hold driver on while not enabled");
    chk_mux_reload: assert property (
        (!SCAN_CONTROL_IN_I)[*4] |-> MUX_CHANNEL_O == 3'h0 && !MUX_ENABLE_O)
        else $error("counter not reloaded");
    chk_mux_step: assert property (
        !$stable(MUX_CHANNEL_O) && MUX_CHANNEL_O != 3'h0
        |-> MUX_CHANNEL_O == $past(MUX_CHANNEL_O) + 3'h1)
        else $error("channel did not step by one");
    chk_level_pin: assert property (
        $rose(HOLD_TRIGGER_PIN_I) && CONFIG_O[2:0] == 3'h1
        |-> ##[1:7] TRACK_HOLD_O)
        else $error("track/hold did not follow trigger pin");
    chk_edge_line: assert property (
        $fell(CHASSIS_HOLD_LINE_I) && CONFIG_O[2:0] == 3'h7
        && $stable(SCAN_CONTROL_IN_I) |-> ##[1:7] TRACK_HOLD_O)
        else $error("chassis line fall did not hold");
endmodule

bind mht_core mht_core_asserts u_mht_core_asserts (
    .REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I),
    .SLOT_ZERO_SELECT_N_I(SLOT_ZERO_SELECT_N_I),
    .HOST_DATA_ADDR_FLAG_I(HOST_DATA_ADDR_FLAG_I),
    .SCAN_CONTROL_IN_I(SCAN_CONTROL_IN_I),
    .HOLD_TRIGGER_PIN_I(HOLD_TRIGGER_PIN_I),
    .CHASSIS_HOLD_LINE_I(CHASSIS_HOLD_LINE_I),
    .SLOT_SELECT_N_O(SLOT_SELECT_N_O), .SERIAL_OUT_LINE_O(SERIAL_OUT_LINE_O),
    .CONFIG_O(CONFIG_O), .MUX_CHANNEL_O(MUX_CHANNEL_O),
    .MUX_ENABLE_O(MUX_ENABLE_O), .TRACK_HOLD_O(TRACK_HOLD_O),
    .TRACK_HOLD_OE_O(TRACK_HOLD_OE_O));

/* File: tb/mht_host_model.sv */
/*
 * Acquisition board model driving the serial link.
 * Assumes its tasks are entered just after a rising edge of clk_i.
 */
module mht_host_model (
    input  wire logic clk_i,
    input  wire logic sdo_i,
    output logic      sclk_o,
    output logic      sdi_o,
    output logic      flag_o,
    output logic      szn_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        sclk_o = 1'b1;
        sdi_o = 1'b0;
        flag_o = 1'b0;
        szn_o = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // Data moves mid-high so it is settled well before the rise
    task automatic xfer(input logic d, output logic q);
        tick(2);
        sdi_o = d;
        tick(2);
        sclk_o = 1'b0;
        tick(4);
        q = sdo_i;
        sclk_o = 1'b1;
    endtask
    task automatic select(input logic [15:0] n);
        logic q;
        szn_o = 1'b0;
        for (int i = 15; i >= 0; i--) xfer(n[i], q);
        tick(2);
        szn_o = 1'b1;
        tick(8);
    endtask
    task automatic finish();
        szn_o = 1'b0;
        tick(8);
        select(16'h0000);
    endtask
    task automatic cfg_write(input logic [31:0] v);
        logic q;
        flag_o = 1'b0;
        for (int i = 31; i >= 0; i--) xfer(v[i], q);
        tick(8);
    endtask
    // Unused data line toggles so a stale level is never mistaken for data
    task automatic id_read(output logic [31:0] id, output logic tail);
        logic q;
        flag_o = 1'b1;
        xfer(~sdi_o, q);
        for (int i = 31; i >= 0; i--) begin
            xfer(~sdi_o, q);
            id[i] = q;
        end
        xfer(~sdi_o, tail);
        tick(8);
    endtask
endmodule

/* File: tb/mht_core_tb_top.sv */
/*
 * Self-checking bench for mht_core with the host model on the link.
 * Assumes design, checker and host model are compiled before it.
 */
module mht_core_tb_top;
    import mht_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    // Arbitrary; MSB set so a wrapping shifter would show in the tail
    localparam logic [31:0] ID = 32'hda3c_0f96;
    localparam logic [15:0] GOOD = 16'h012b;    // Chassis 9, slot 11
    logic        clk, rst_n, scan_p, scan_c, ext_pin, ext_pull, tail;
    logic        sclk, sdi, flag, szn, sdo, ss_n, pin_o, pin_oe, e1;
    logic        chs_o, chs_oe, th, th_oe, mux_en;
    logic [2:0]  chan;
    logic [31:0] cfg, v, id;
    int          n_fail, total_checks, n;
    wire logic   pin_w = pin_oe ? pin_o : ext_pin;
    wire logic   chs_w = (chs_oe ? chs_o : 1'b1) & ~ext_pull;

    mht_core #(.MODULE_ID(ID)) u_mht_core (
        .REF_CLK_I(clk), .RST_N_I(rst_n), .SERIAL_CLOCK_LINE_I(sclk),
        .SERIAL_IN_LINE_I(sdi), .HOST_DATA_ADDR_FLAG_I(flag),
        .SLOT_ZERO_SELECT_N_I(szn), .SERIAL_OUT_LINE_O(sdo),
        .SLOT_SELECT_N_O(ss_n), .SLOT_NUMBER_I(5'h0b),
        .CHASSIS_ADDR_I(5'h09), .CONFIG_O(cfg),
        .SCAN_ADVANCE_PULSE_I(scan_p), .SCAN_CONTROL_IN_I(scan_c),
        .MUX_CHANNEL_O(chan), .MUX_ENABLE_O(mux_en),
        .HOLD_TRIGGER_PIN_I(pin_w), .HOLD_TRIGGER_PIN_O(pin_o),
        .HOLD_TRIGGER_PIN_OE_O(pin_oe), .CHASSIS_HOLD_LINE_I(chs_w),
        .CHASSIS_HOLD_LINE_O(chs_o), .CHASSIS_HOLD_LINE_OE_O(chs_oe),
        .TRACK_HOLD_O(th), .TRACK_HOLD_OE_O(th_oe));
    mht_host_model u_mht_host_model (
        .clk_i(clk), .sdo_i(sdo), .sclk_o(sclk), .sdi_o(sdi),
        .flag_o(flag), .szn_o(szn));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    function automatic logic hold_exp(input logic [2:0] m, input logic p, u);
        return m[2] ? u : p;
    endfunction
    function automatic logic drv_exp(input logic [2:0] m, input logic p, u);
        return m[2] ? u : ~p;
    endfunction
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string s, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Quiet trigger inputs keep transient modes of the shift from holding
    task automatic setcfg(input logic [2:0] m);
        ext_pin = 1'b0;
        ext_pull = 1'b0;
        v = $urandom;
        v[2:0] = m;
        u_mht_host_model.finish();
        u_mht_host_model.select(GOOD);
        u_mht_host_model.cfg_write(v);
    endtask

    initial begin
        void'($urandom(32'ha9e0));
        n_fail = 0;
        total_checks = 0;
        rst_n = 1'b0;
        scan_p = 1'b0;
        scan_c = 1'b0;
        ext_pin = 1'b0;
        ext_pull = 1'b0;
        tick(20);
        rst_n = 1'b1;
        tick(10);
        chk("ss_n", 1, ss_n);
        chk("cfg", 0, cfg);
        chk("chan", 0, chan);
        u_mht_host_model.select(16'h012c);
        chk("ss_n other", 1, ss_n);
        u_mht_host_model.cfg_write($urandom);
        chk("cfg unsel", 0, cfg);
        setcfg(3'h0);
        chk("ss_n", 0, ss_n);
        chk("cfg", v, cfg);
        chk("th_oe", 0, th_oe);
        for (int r = 0; r < 2; r++) begin
            u_mht_host_model.id_read(id, tail);
            chk("id", ID, id);
            chk("tail", 0, tail);
            chk("cfg kept", v, cfg);
            u_mht_host_model.finish();
            chk("ss_n end", 1, ss_n);
            u_mht_host_model.select(GOOD);
        end
        $display("test serial done");
        scan_c = 1'b1;
        tick(4);
        n = $urandom_range(20, 9);
        repeat (n) begin
            scan_p = 1'b1;
            tick(4);
            scan_p = 1'b0;
            tick(4);
        end
        chk("chan", n % 8, chan);
        chk("mux_en", 1, mux_en);
        scan_c = 1'b0;
        tick(6);
        chk("chan", 0, chan);
        chk("mux_en", 0, mux_en);
        $display("test scan done");
        for (int m = 1; m < 6; m += 4) begin
            setcfg(m[2:0]);
            repeat (6) begin
                ext_pin = 1'($urandom);
                ext_pull = m[2] & 1'($urandom);
                tick(8);
                e1 = hold_exp(m[2:0], ext_pin, ext_pull);
                chk("th", e1, th);
                chk("th_oe", 1, th_oe);
                e1 = drv_exp(m[2:0], ext_pin, ext_pull);
                chk("drive", e1, m[2] ? pin_w : chs_w);
            end
        end
        for (int m = 3; m < 8; m += 4) begin
            setcfg(m[2:0]);
            scan_c = ~scan_c;
            tick(8);
            chk("track", 0, th);
            if (m == 3)
                ext_pin = 1'b1;
            else
                ext_pull = 1'b1;
            tick(8);
            chk("hold", 1, th);
            chk("pass", 1, m == 3 ? !chs_w : pin_w);
            scan_c = ~scan_c;
            tick(8);
            chk("track", 0, th);
            chk("pass", 0, m == 3 ? !chs_w : pin_w);
        end
        $display("test hold done");
        rst_n = 1'b0;
        tick(2);
        rst_n = 1'b1;
        tick(10);
        chk("ss_n rst", 1, ss_n);
        chk("cfg rst", 0, cfg);
        chk("th_oe rst", 0, th_oe);
        $display("test reset done");
        conclude();
    end
    initial begin
        #1ms;
        n_fail++;
        conclude();
    end
endmodule
